// File: fps_feedback_decode.sv
// feedback path select decoder with wishbone register access
`timescale 1ns/1ps
// Functional notes
// - receiver one: present high, choice low means transmitter 1 looped back
// - receiver one: both selects high means transmitter 2 looped back
// - receiver one: present low means no route, no leakage tracking
// - receiver two: present high picks transmitter by choice level
// - receiver two: present low means no route, tracking skipped
// - each select comes from a software level or a general pin
// - up to four select pins, each picked from pins zero to fifteen
// - choice from a pin while present stays a fixed software level
// - route outputs follow the selects continuously, run only fed transmitter
// - wide observation bandwidth: one receiver only, no switching between them
// - tracking enable pin unsupported: held at invalid pin, enable cleared
// - per select polarity: 0 normal, 1 inverts the pin level
// - per select source: 0 software level, 1 assigned pin
module fps_feedback_decode
    import fps_pkg::*;
#(
    parameter int unsigned GPIO_W = NUM_GPIO
)(
    input  wire logic                clk,
    input  wire logic                rst,
    // wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [DATA_W-1:0]   wb_dat_i,
    output logic      [DATA_W-1:0]   wb_dat_o,
    output logic                     wb_ack_o,
    // general-purpose pins from the baseband controller
    input  wire logic [GPIO_W-1:0]   gpio_in,
    // decoded routes for the calibration scheduler
    output fps_route_t               rx1_route,
    output fps_route_t               rx2_route
);

    // register state
    logic [5:0]           ctrl_r;
    fps_pin_cfg_t         pin_cfg_r [NUM_SEL];
    logic [GPIO_W-1:0]    gpio_meta_r;
    logic [GPIO_W-1:0]    gpio_sync_r;
    logic [NUM_SEL-1:0]   sel_lvl;
    fps_route_t           rx1_nxt;
    fps_route_t           rx2_nxt;
    logic                 wb_req;
    logic                 wr_lo;
    logic                 wr_hi;
    logic [DATA_W-1:0]    rd_nxt;
    fps_pin_cfg_t         wr_cfg;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lo  = wb_req && wb_we_i && wb_sel_i[0];
    assign wr_hi  = wb_req && wb_we_i && wb_sel_i[1];

    // present low blocks the receiver whatever the choice level says
    function automatic fps_route_t route_of(input logic choice,
                                            input logic present);
        fps_route_t r;
        r.tx1_fed = present && !choice;
        r.tx2_fed = present && choice;
        return r;
    endfunction

    function automatic fps_pin_cfg_t pin_cfg_of(input logic [15:0] d);
        fps_pin_cfg_t c;
        c.enable   = d[PIN_EN_BIT];
        c.polarity = d[PIN_POL_BIT];
        c.pin      = d[PIN_IDX_LSB +: PIN_IDX_W];
        return c;
    endfunction

    // one field split shared by every pin slot write
    assign wr_cfg = pin_cfg_of(wb_dat_i[15:0]);

    function automatic logic [DATA_W-1:0] pin_rd(input fps_pin_cfg_t c);
        logic [DATA_W-1:0] d;
        d = '0;
        d[PIN_EN_BIT] = c.enable;
        d[PIN_POL_BIT] = c.polarity;
        d[PIN_IDX_LSB +: PIN_IDX_W] = c.pin;
        return d;
    endfunction

    // pins are asynchronous to us in practice; only the second stage is read
    always_ff @(posedge clk) begin
        if (rst) begin
            gpio_meta_r <= '0;
            gpio_sync_r <= '0;
        end else begin
            gpio_meta_r <= gpio_in;
            gpio_sync_r <= gpio_meta_r;
        end
    end

    // control register: software levels, bandwidth mode, active receiver
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_lo && wb_adr_i == FPS_CTRL_OFS) begin
            ctrl_r <= wb_dat_i[5:0];
        end
    end

    // pin configuration registers, one per select slot
    generate
        for (genvar g = 0; g < NUM_SEL; g++) begin : g_pin_cfg
            localparam logic [7:0] OFS = FPS_PIN0_OFS + 8'(4 * g);
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_cfg_r[g] <= PIN_CFG_RST;
                end else if (wb_req && wb_we_i && wb_adr_i == OFS) begin
                    // byte lanes: pin index low, polarity and enable high
                    if (wr_lo) begin
                        pin_cfg_r[g].pin <= wr_cfg.pin;
                    end
                    if (wr_hi) begin
                        pin_cfg_r[g].polarity <= wr_cfg.polarity;
                        pin_cfg_r[g].enable   <= wr_cfg.enable;
                    end
                end
            end

            // pin index beyond fifteen reads as a low pin level
            always_comb begin
                logic pin_lvl;
                pin_lvl = 1'b0;
                if (pin_cfg_r[g].pin < 5'(GPIO_W)) begin
                    pin_lvl = gpio_sync_r[pin_cfg_r[g].pin[3:0]];
                end
                if (pin_cfg_r[g].enable) begin
                    sel_lvl[g] = pin_lvl ^ pin_cfg_r[g].polarity;
                end else begin
                    sel_lvl[g] = ctrl_r[CTRL_SWLVL_LSB + g];
                end
            end
        end
    endgenerate

    // is the controller's duty; present is trusted as given
    always_comb begin
        rx1_nxt = route_of(sel_lvl[0], sel_lvl[1]);
        rx2_nxt = route_of(sel_lvl[2], sel_lvl[3]);
        // wide bandwidth: the inactive receiver is masked off entirely
        if (ctrl_r[CTRL_WIDEBW_BIT]) begin
            if (ctrl_r[CTRL_ACTRX_BIT]) begin
                rx1_nxt = '0;
            end else begin
                rx2_nxt = '0;
            end
        end
    end

    // decoded routes tracked every cycle for the scheduler
    always_ff @(posedge clk) begin
        if (rst) begin
            rx1_route <= '0;
            rx2_route <= '0;
        end else begin
            rx1_route <= rx1_nxt;
            rx2_route <= rx2_nxt;
        end
    end

    // read mux; unmapped offsets read zero and still acknowledge
    always_comb begin
        rd_nxt = '0;
        if (wb_adr_i == FPS_CTRL_OFS) begin
            rd_nxt[5:0] = ctrl_r;
        end else if (wb_adr_i == FPS_PIN0_OFS) begin
            rd_nxt = pin_rd(pin_cfg_r[0]);
        end else if (wb_adr_i == FPS_PIN1_OFS) begin
            rd_nxt = pin_rd(pin_cfg_r[1]);
        end else if (wb_adr_i == FPS_PIN2_OFS) begin
            rd_nxt = pin_rd(pin_cfg_r[2]);
        end else if (wb_adr_i == FPS_PIN3_OFS) begin
            rd_nxt = pin_rd(pin_cfg_r[3]);
        end else if (wb_adr_i == FPS_TRKPIN_OFS) begin
            // tracking enable pin has no storage; always invalid, disabled
            rd_nxt = pin_rd(PIN_CFG_RST);
        end else if (wb_adr_i == FPS_STATUS_OFS) begin
            rd_nxt[STAT_ROUTE_LSB +: 4] = {rx2_route, rx1_route};
            rd_nxt[STAT_LVL_LSB +: NUM_SEL] = sel_lvl;
            rd_nxt[STAT_SYNC_LSB +: GPIO_W] = gpio_sync_r;
        end
    end

    // single wait-free answer: ack one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

endmodule

// File: fps_pkg.sv
// shared constants and types for the feedback path select decoder
package fps_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] FPS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] FPS_PIN0_OFS   = 8'h04;
    localparam logic [7:0] FPS_PIN1_OFS   = 8'h08;
    localparam logic [7:0] FPS_PIN2_OFS   = 8'h0C;
    localparam logic [7:0] FPS_PIN3_OFS   = 8'h10;
    localparam logic [7:0] FPS_TRKPIN_OFS = 8'h14;
    localparam logic [7:0] FPS_STATUS_OFS = 8'h18;

    // select slot order: rx1 choice, rx1 present, rx2 choice, rx2 present
    localparam int unsigned NUM_SEL = 4;

    // control register fields
    localparam int unsigned CTRL_SWLVL_LSB = 0;
    localparam int unsigned CTRL_WIDEBW_BIT = 4;
    localparam int unsigned CTRL_ACTRX_BIT = 5;
    localparam logic [5:0]  CTRL_RST       = 6'h00;

    // pin configuration fields
    localparam int unsigned PIN_IDX_LSB = 0;
    localparam int unsigned PIN_IDX_W   = 5;
    localparam int unsigned PIN_POL_BIT = 8;
    localparam int unsigned PIN_EN_BIT  = 9;
    localparam int unsigned NUM_GPIO    = 16;
    localparam logic [4:0]  PIN_INVALID = 5'h1F;

    // status register fields
    localparam int unsigned STAT_ROUTE_LSB = 0;
    localparam int unsigned STAT_LVL_LSB   = 4;
    localparam int unsigned STAT_SYNC_LSB  = 8;

    typedef struct packed {
        logic       enable;
        logic       polarity;
        logic [4:0] pin;
    } fps_pin_cfg_t;

    localparam fps_pin_cfg_t PIN_CFG_RST = '{
        enable:   1'b0,
        polarity: 1'b0,
        pin:      PIN_INVALID
    };

    // one receiver's decoded route, one-hot or zero
    typedef struct packed {
        logic tx2_fed;
        logic tx1_fed;
    } fps_route_t;

endpackage

// File: fps_feedback_decode_asserts.sv
// assertion checker for the feedback path select decoder
`timescale 1ns/1ps
module fps_chk
    import fps_pkg::*;
#(
    parameter int unsigned GPIO_W = 16
)(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [GPIO_W-1:0] gpio_in,
    input wire fps_route_t        rx1_route,
    input wire fps_route_t        rx2_route
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire req = wb_cyc_i && wb_stb_i;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_rx1_code: assert property ($onehot0(rx1_route))
        else $error("rx1 route not one-hot");
    a_rx2_code: assert property ($onehot0(rx2_route))
        else $error("rx2 route not one-hot");
    // a route moves only after a bus access or three edges after a pin move
    a_rx1_latency: assert property ($changed(rx1_route) |-> wb_ack_o ||
        $past(wb_ack_o) || $past(gpio_in, 3) != $past(gpio_in, 4))
        else $error("rx1 route moved at wrong time");
    a_rx2_latency: assert property ($changed(rx2_route) |-> wb_ack_o ||
        $past(wb_ack_o) || $past(gpio_in, 3) != $past(gpio_in, 4))
        else $error("rx2 route moved at wrong time");
    a_trk_fixed: assert property (wb_ack_o && $past(req && !wb_we_i &&
        wb_adr_i == 8'h14) |-> wb_dat_o == 32'h0000001F)
        else $error("tracking pin cfg not fixed");
    c_write: cover property (req && wb_we_i && wb_ack_o);
    c_tx2_rx1: cover property (rx1_route == 2'b10);
    c_pin_move: cover property ($changed(rx1_route) && !$past(wb_ack_o));
endmodule
bind fps_feedback_decode fps_chk #(.GPIO_W(GPIO_W)) i_fps_chk (.clk, .rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .gpio_in, .rx1_route, .rx2_route);

// File: fps_bb_ctl.sv
// baseband controller model driving the feedback select pins
`timescale 1ns/1ps
module fps_bb_ctl (
    input  wire logic        clk,
    input  wire logic [1:0]  path,
    output logic      [15:0] gpio
);
    // path 0 tx1 fwd, 1 tx2 fwd, 2 reverse, 3 none; pin 10 choice, 11 present
    // one process owns the whole pin word; unused pins stay low
    always @(posedge clk) begin
        gpio <= {4'h0, !path[1], path[0], 10'h000};
    end
endmodule

// File: testbench.sv
// self-checking bench for the feedback path select decoder
`timescale 1ns/1ps
module testbench;
    import fps_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, rdat, dat_o;
    logic        ack;
    logic [15:0] gpio;
    logic [1:0]  path = 2'h3;
    fps_route_t  r1, r2;
    int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
    always #5 clk = ~clk;
    fps_feedback_decode i_fps_feedback_decode (.clk, .rst, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .gpio_in(gpio),
        .rx1_route(r1), .rx2_route(r2));
    fps_bb_ctl i_fps_bb_ctl (.clk, .path, .gpio);
    task automatic print_verdict();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // no wait bound here: the global cycle ceiling cuts a hang
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic [1:0] rt(logic p, logic c);
        return p ? (c ? 2'b10 : 2'b01) : 2'b00;
    endfunction
    task automatic chk(logic [1:0] e1, logic [1:0] e2);
        repeat (5) @(posedge clk);
        cmp("rx1_route", {30'h0, e1}, {30'h0, r1});
        cmp("rx2_route", {30'h0, e2}, {30'h0, r2});
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, 8'h04, 32'h0);
        cmp("pin0_cfg", 32'h0000001F, rdat);
        acc(1'b1, 8'h14, 32'h00000200);
        acc(1'b0, 8'h14, 32'h0);
        cmp("trk_cfg", 32'h0000001F, rdat);
        acc(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h00000000, rdat);
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, 8'h00, i);
            chk(rt(i[1], i[0]), rt(i[3], i[2]));
        end
        acc(1'b1, 8'h00, 32'h0);
        acc(1'b1, 8'h04, 32'h0000020A);
        // pass 2: choice follows pin 10; present follows pin 11, then pin 11 inverted, then a fixed software level
        for (int p = 0; p < 3; p++) begin
            acc(1'b1, 8'h08, p == 2 ? 32'h0000000B : {22'h0, 1'b1, p[0], 8'h0B});
            acc(1'b1, 8'h00, p == 2 ? 32'h00000002 : 32'h0);
            for (int i = 0; i < 4; i++) begin
                path <= i[1:0];
                chk(rt(p == 2 || (!i[1] ^ p[0]), i[0]), 2'b00);
            end
        end
        acc(1'b1, 8'h00, 32'h0000001F);
        chk(2'b10, 2'b00);
        acc(1'b1, 8'h00, 32'h0000003F);
        chk(2'b00, 2'b10);
        acc(1'b0, 8'h18, 32'h0);
        cmp("status", 32'h000400F8, rdat);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk(2'b00, 2'b00);
        acc(1'b0, 8'h08, 32'h0);
        cmp("pin1_cfg", 32'h0000001F, rdat);
        print_verdict();
    end
endmodule
